// file: bcr_pkg.sv
// Purpose: shared constants of the ber tally and resync block
// Assumes: 8-bit register address, 32-bit register data
// Notes:   offsets are byte addresses of 32-bit words
package bcr_pkg;
  // register offsets
  localparam logic [7:0]  REG_CTRL     = 8'h00;
  localparam logic [7:0]  REG_THRESH   = 8'h04;
  localparam logic [7:0]  REG_TARGET   = 8'h08;
  localparam logic [7:0]  REG_STATUS   = 8'h0c;
  localparam logic [7:0]  REG_PUB_BITS = 8'h10;
  localparam logic [7:0]  REG_PUB_ERRS = 8'h14;
  localparam logic [7:0]  REG_PUB_LOSS = 8'h18;
  localparam logic [7:0]  REG_PROGRESS = 8'h1c;
  localparam logic [7:0]  REG_LOG_BITS = 8'h20;
  localparam logic [7:0]  REG_LOG_ERRS = 8'h24;
  localparam logic [7:0]  REG_LOG_CNT  = 8'h28;
  // control and threshold field positions
  localparam int          CTRL_START   = 0;
  localparam int          CTRL_STOP    = 1;
  localparam int          CTRL_CLEAR   = 2;
  localparam int          CTRL_MODE_LO = 4;
  localparam int          CTRL_RELOCK  = 8;
  localparam int          CTRL_KEEP    = 9;
  localparam int          CTRL_ERRMODE = 10;
  localparam int          THR_YSEL_LO  = 16;
  // measurement modes
  localparam logic [1:0]  MODE_CONT    = 2'h0;
  localparam logic [1:0]  MODE_SINGLE  = 2'h1;
  localparam logic [1:0]  MODE_ENDLESS = 2'h2;
  // window lengths
  localparam logic [15:0] WIN_500      = 16'h01f4;
  localparam logic [15:0] WIN_5000     = 16'h1388;
  localparam logic [15:0] WIN_50000    = 16'hc350;
  // reset values
  localparam logic [1:0]  RST_MODE     = MODE_SINGLE;
  localparam logic [15:0] RST_X        = 16'h00c8;
  localparam logic [1:0]  RST_YSEL     = 2'h0;
  localparam logic [31:0] RST_TARGET   = 32'h000003e8;
  // limits and timing counts
  localparam logic [31:0] BITS_MAX     = 32'hffffffff;
  localparam logic [15:0] LOSS_MAX     = 16'hffff;
  localparam logic [4:0]  SYNC_LEN     = 5'h12;
  // run states
  typedef enum logic [1:0] {ST_STOP, ST_SYNC, ST_MEAS} bcr_state_e;
endpackage

// file: bcr_sync.sv
// Purpose: two-flop synchroniser for a group of slow inputs
// Assumes: inputs change no faster than a few clk periods
// Notes:   first stage is read only by the second stage
`timescale 1ns/100ps
`default_nettype none
module bcr_sync #(
  parameter int W = 2
) (
  // clock and reset
  input  wire logic         clk_in,
  input  wire logic         rst_b_in,
  // async side and synced side
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] sync_nxt;

  always_comb
  begin
    meta_nxt = async_in;
    sync_nxt = meta_r;
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      meta_r   <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_r   <= meta_nxt;
      sync_out <= sync_nxt;
    end
  end
endmodule
`default_nettype wire

// file: bcr_ber_count.sv
// Purpose: ber tally, count clear and lost-lock resync supervision
// Assumes: link clock and data from the device under test are async
// Notes:   reference pattern is a self-seeded pn9 (x^9+x^5+1)
// Operation
// RULE1 - count clear ignored in continuous mode
// RULE2 - running clear zeroes tallies, keeps lock state
// RULE3 - running clear leaves progress untouched
// RULE4 - running clear logs rate at clear start
// RULE5 - stopped clear zeroes bits, rate, progress, no log
// RULE6 - continuous publishes at completion, then restarts
// RULE7 - single/endless publish live, freeze at end
// RULE8 - relock enabled: detect loss and resynchronise
// RULE9 - relock disabled: no loss detection at all
// RULE10 - loss when X errors within Y bits
// RULE11 - Y is 500/5000/50000, X 1..Y/2
// RULE12 - threshold and action only with relock enabled
// RULE13 - loss action clears or keeps bit tally
// RULE14 - loss halts counting; default 200 in 500
// RULE15 - always sync first, count only when locked
// RULE16 - operator picks 50/500 below 0.3 percent
// RULE17 - single run ends at 65535 losses
// RULE18 - loss count increments, zeroed at run start
//
// Local design decisions: strobed register access and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module bcr_ber_count (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_b_in,
  // register port
  input  wire logic [7:0]  addr_in,
  input  wire logic [31:0] wr_data_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [31:0] rd_data_out,
  // link from device under test
  input  wire logic        link_clk_in,
  input  wire logic        link_data_in,
  // status
  output logic             locked_out,
  output logic             running_out
);
  logic [1:0]  lnk_s;
  logic        lclk_prev_r;
  logic        bit_evt;
  logic        rx;
  logic        exp_bit;
  logic        err;

  bcr_sync #(.W(2)) u_sync (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_in),
    .async_in ({link_clk_in, link_data_in}),
    .sync_out (lnk_s)
  );

  // configuration group
  logic [1:0]  mode_r, mode_nxt;
  logic        relock_r, relock_nxt;
  logic        keep_r, keep_nxt;
  logic        errmode_r, errmode_nxt;
  logic [15:0] x_r, x_nxt;
  logic [1:0]  ysel_r, ysel_nxt;
  logic [31:0] target_r, target_nxt;
  logic        wr_ctrl;
  logic        clr_req, start_req, stop_req;

  // run group
  bcr_pkg::bcr_state_e state_r, state_nxt;
  logic [8:0]  pn_r, pn_nxt;
  logic [4:0]  good_r, good_nxt;
  logic [31:0] bits_r, bits_nxt, errs_r, errs_nxt, prog_r, prog_nxt;
  logic [15:0] loss_r, loss_nxt, win_r, win_nxt, werr_r, werr_nxt;
  logic [31:0] pub_bits_r, pub_bits_nxt, pub_errs_r, pub_errs_nxt;
  logic [15:0] pub_loss_r, pub_loss_nxt, log_cnt_r, log_cnt_nxt;
  logic [31:0] log_bits_r, log_bits_nxt, log_errs_r, log_errs_nxt;
  logic        done_r, done_nxt;
  logic [15:0] y_len, x_eff, werr_sum;
  logic [31:0] tgt_eff;
  logic        loss_hit, done_hit, run_clr;
  logic [31:0] rd_nxt;

  always_comb
  begin
    bit_evt  = lnk_s[1] & ~lclk_prev_r;
    rx       = lnk_s[0];
    exp_bit  = pn_r[8] ^ pn_r[4];
    err      = rx ^ exp_bit;
    wr_ctrl  = wr_in && (addr_in == bcr_pkg::REG_CTRL);
    start_req = wr_ctrl && wr_data_in[bcr_pkg::CTRL_START];
    stop_req  = wr_ctrl && wr_data_in[bcr_pkg::CTRL_STOP];
    clr_req   = wr_ctrl && wr_data_in[bcr_pkg::CTRL_CLEAR]
                && (mode_r != bcr_pkg::MODE_CONT); // RULE1
    run_clr   = clr_req && (state_r != bcr_pkg::ST_STOP);
    // only three window lengths exist; a stray code falls back to 500
    case (ysel_r)
      2'h1:    y_len = bcr_pkg::WIN_5000; // RULE11
      2'h2:    y_len = bcr_pkg::WIN_50000;
      default: y_len = bcr_pkg::WIN_500;
    endcase
    if (x_r == 16'h0000)
      x_eff = 16'h0001; // RULE11
    else if (x_r > (y_len >> 1))
      x_eff = y_len >> 1;
    else
      x_eff = x_r;
    werr_sum = werr_r + {15'h0000, err};
    loss_hit = (state_r == bcr_pkg::ST_MEAS) && bit_evt && relock_r
               && (werr_sum >= x_eff); // RULE8 RULE9 RULE10 RULE12
    tgt_eff  = (mode_r == bcr_pkg::MODE_ENDLESS) ? bcr_pkg::BITS_MAX : target_r;
    done_hit = (state_r == bcr_pkg::ST_MEAS)
               && ((prog_r >= tgt_eff)
                   || (errmode_r && (bits_r == bcr_pkg::BITS_MAX))
                   || (relock_r && (loss_r == bcr_pkg::LOSS_MAX))); // RULE17
  end

  always_comb
  begin
    mode_nxt    = mode_r;
    relock_nxt  = relock_r;
    keep_nxt    = keep_r;
    errmode_nxt = errmode_r;
    x_nxt       = x_r;
    ysel_nxt    = ysel_r;
    target_nxt  = target_r;
    if (wr_ctrl)
    begin
      mode_nxt    = wr_data_in[bcr_pkg::CTRL_MODE_LO +: 2];
      relock_nxt  = wr_data_in[bcr_pkg::CTRL_RELOCK];
      keep_nxt    = wr_data_in[bcr_pkg::CTRL_KEEP];
      errmode_nxt = wr_data_in[bcr_pkg::CTRL_ERRMODE];
    end
    if (wr_in && (addr_in == bcr_pkg::REG_THRESH))
    begin
      x_nxt    = wr_data_in[15:0];
      ysel_nxt = wr_data_in[bcr_pkg::THR_YSEL_LO +: 2];
    end
    if (wr_in && (addr_in == bcr_pkg::REG_TARGET))
      target_nxt = wr_data_in;
  end

  always_comb
  begin
    state_nxt    = state_r;
    pn_nxt       = pn_r;
    good_nxt     = good_r;
    bits_nxt     = bits_r;
    errs_nxt     = errs_r;
    prog_nxt     = prog_r;
    loss_nxt     = loss_r;
    win_nxt      = win_r;
    werr_nxt     = werr_r;
    pub_bits_nxt = pub_bits_r;
    pub_errs_nxt = pub_errs_r;
    pub_loss_nxt = pub_loss_r;
    log_bits_nxt = log_bits_r;
    log_errs_nxt = log_errs_r;
    log_cnt_nxt  = log_cnt_r;
    done_nxt     = done_r;
    if ((mode_r != bcr_pkg::MODE_CONT) && (state_r != bcr_pkg::ST_STOP))
    begin
      pub_bits_nxt = bits_r; // RULE7
      pub_errs_nxt = errs_r;
      pub_loss_nxt = loss_r;
    end
    case (state_r)
      bcr_pkg::ST_STOP:
      begin
      end
      bcr_pkg::ST_SYNC:
      begin
        if (bit_evt)
        begin
          pn_nxt   = {pn_r[7:0], rx};
          good_nxt = err ? 5'h00 : good_r + 5'h01;
          if (!err && (good_r + 5'h01 == bcr_pkg::SYNC_LEN))
          begin
            state_nxt = bcr_pkg::ST_MEAS; // RULE15
            win_nxt   = 16'h0000;
            werr_nxt  = 16'h0000;
          end
        end
      end
      bcr_pkg::ST_MEAS:
      begin
        if (done_hit && (mode_r == bcr_pkg::MODE_CONT))
        begin
          pub_bits_nxt = bits_r; // RULE6
          pub_errs_nxt = errs_r;
          pub_loss_nxt = loss_r;
          state_nxt    = bcr_pkg::ST_SYNC;
          good_nxt     = 5'h00;
          bits_nxt     = 32'h00000000;
          errs_nxt     = 32'h00000000;
          prog_nxt     = 32'h00000000;
          loss_nxt     = 16'h0000;
        end
        else if (done_hit)
        begin
          state_nxt = bcr_pkg::ST_STOP;
          done_nxt  = 1'b1;
        end
        else if (loss_hit)
        begin
          state_nxt = bcr_pkg::ST_SYNC; // RULE14
          good_nxt  = 5'h00;
          loss_nxt  = loss_r + 16'h0001; // RULE18
          if (!keep_r)
            bits_nxt = 32'h00000000; // RULE13
        end
        else if (bit_evt)
        begin
          pn_nxt   = {pn_r[7:0], exp_bit};
          bits_nxt = bits_r + 32'h00000001;
          errs_nxt = errs_r + {31'h00000000, err};
          prog_nxt = prog_r + (errmode_r ? {31'h00000000, err} : 32'h00000001);
          if (win_r + 16'h0001 == y_len)
          begin
            win_nxt  = 16'h0000;
            werr_nxt = 16'h0000;
          end
          else
          begin
            win_nxt  = win_r + 16'h0001;
            werr_nxt = werr_sum;
          end
        end
      end
      default:
        state_nxt = bcr_pkg::ST_STOP;
    endcase
    if (clr_req && (state_r == bcr_pkg::ST_STOP))
    begin
      bits_nxt = 32'h00000000; // RULE5
      errs_nxt = 32'h00000000;
      prog_nxt = 32'h00000000;
      // the frozen bit and error result is all software can see, so it clears as well
      pub_bits_nxt = 32'h00000000;
      pub_errs_nxt = 32'h00000000;
    end
    else if (run_clr)
    begin
      log_bits_nxt = bits_r; // RULE4
      log_errs_nxt = errs_r;
      log_cnt_nxt  = log_cnt_r + 16'h0001;
      bits_nxt     = 32'h00000000; // RULE2
      errs_nxt     = 32'h00000000;
      loss_nxt     = 16'h0000;
      prog_nxt     = prog_r; // RULE3
    end
    if (start_req)
    begin
      state_nxt = bcr_pkg::ST_SYNC; // RULE15
      good_nxt  = 5'h00;
      bits_nxt  = 32'h00000000;
      errs_nxt  = 32'h00000000;
      prog_nxt  = 32'h00000000;
      loss_nxt  = 16'h0000; // RULE18
      done_nxt  = 1'b0;
    end
    if (stop_req)
      state_nxt = bcr_pkg::ST_STOP;
  end

  always_comb
  begin
    rd_nxt = 32'h00000000;
    if (rd_in)
    begin
      case (addr_in)
        bcr_pkg::REG_CTRL:     rd_nxt = {21'h000000, errmode_r, keep_r, relock_r,
                                         2'h0, mode_r, 4'h0};
        bcr_pkg::REG_THRESH:   rd_nxt = {14'h0000, ysel_r, x_r};
        bcr_pkg::REG_TARGET:   rd_nxt = target_r;
        bcr_pkg::REG_STATUS:   rd_nxt = {29'h00000000, done_r, state_r};
        bcr_pkg::REG_PUB_BITS: rd_nxt = pub_bits_r;
        bcr_pkg::REG_PUB_ERRS: rd_nxt = pub_errs_r;
        bcr_pkg::REG_PUB_LOSS: rd_nxt = {16'h0000, pub_loss_r};
        bcr_pkg::REG_PROGRESS: rd_nxt = prog_r;
        bcr_pkg::REG_LOG_BITS: rd_nxt = log_bits_r;
        bcr_pkg::REG_LOG_ERRS: rd_nxt = log_errs_r;
        bcr_pkg::REG_LOG_CNT:  rd_nxt = {16'h0000, log_cnt_r};
        default:               rd_nxt = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      mode_r <= bcr_pkg::RST_MODE;
      relock_r <= 1'b1;
      keep_r <= 1'b0;
      errmode_r <= 1'b0;
      x_r <= bcr_pkg::RST_X; // RULE14
      ysel_r <= bcr_pkg::RST_YSEL;
      target_r <= bcr_pkg::RST_TARGET;
      lclk_prev_r <= 1'b0;
      state_r <= bcr_pkg::ST_STOP;
      pn_r <= 9'h000;
      good_r <= 5'h00;
      bits_r <= 32'h00000000;
      errs_r <= 32'h00000000;
      prog_r <= 32'h00000000;
      loss_r <= 16'h0000;
      win_r <= 16'h0000;
      werr_r <= 16'h0000;
      pub_bits_r <= 32'h00000000;
      pub_errs_r <= 32'h00000000;
      pub_loss_r <= 16'h0000;
      log_bits_r <= 32'h00000000;
      log_errs_r <= 32'h00000000;
      log_cnt_r <= 16'h0000;
      done_r <= 1'b0;
      rd_data_out <= 32'h00000000;
      locked_out <= 1'b0;
      running_out <= 1'b0;
    end
    else
    begin
      mode_r <= mode_nxt;
      relock_r <= relock_nxt;
      keep_r <= keep_nxt;
      errmode_r <= errmode_nxt;
      x_r <= x_nxt;
      ysel_r <= ysel_nxt;
      target_r <= target_nxt;
      lclk_prev_r <= lnk_s[1];
      state_r <= state_nxt;
      pn_r <= pn_nxt;
      good_r <= good_nxt;
      bits_r <= bits_nxt;
      errs_r <= errs_nxt;
      prog_r <= prog_nxt;
      loss_r <= loss_nxt;
      win_r <= win_nxt;
      werr_r <= werr_nxt;
      pub_bits_r <= pub_bits_nxt;
      pub_errs_r <= pub_errs_nxt;
      pub_loss_r <= pub_loss_nxt;
      log_bits_r <= log_bits_nxt;
      log_errs_r <= log_errs_nxt;
      log_cnt_r <= log_cnt_nxt;
      done_r <= done_nxt;
      rd_data_out <= rd_nxt;
      locked_out <= (state_nxt == bcr_pkg::ST_MEAS);
      running_out <= (state_nxt != bcr_pkg::ST_STOP);
    end
  end

  property p_clr_ignored;
    @(posedge clk_in) disable iff (!rst_b_in)
    (wr_ctrl && wr_data_in[bcr_pkg::CTRL_CLEAR] && (mode_r == bcr_pkg::MODE_CONT))
    |=> (log_cnt_r == $past(log_cnt_r));
  endproperty
  a_clr_ignored: assert property (p_clr_ignored) else $error("clear acted in continuous"); // RULE1

  property p_run_clr;
    @(posedge clk_in) disable iff (!rst_b_in)
    (run_clr && !start_req && !stop_req && !bit_evt && !done_hit)
    |=> (bits_r == 32'h0) && (errs_r == 32'h0) && (loss_r == 16'h0)
        && (state_r == $past(state_r)) && (prog_r == $past(prog_r));
  endproperty
  a_run_clr: assert property (p_run_clr) else $error("running clear wrong"); // RULE2 RULE3

  property p_log;
    @(posedge clk_in) disable iff (!rst_b_in)
    run_clr |=> (log_bits_r == $past(bits_r)) && (log_errs_r == $past(errs_r))
                && (log_cnt_r == $past(log_cnt_r) + 16'h0001);
  endproperty
  a_log: assert property (p_log) else $error("clear log entry wrong"); // RULE4

  property p_stop_clr;
    @(posedge clk_in) disable iff (!rst_b_in)
    (clr_req && (state_r == bcr_pkg::ST_STOP) && !start_req)
    |=> (bits_r == 32'h0) && (prog_r == 32'h0) && (pub_bits_r == 32'h0)
        && $stable(log_cnt_r);
  endproperty
  a_stop_clr: assert property (p_stop_clr) else $error("stopped clear wrong"); // RULE5

  property p_cont_hold;
    @(posedge clk_in) disable iff (!rst_b_in)
    ((mode_r == bcr_pkg::MODE_CONT) && !done_hit) |=> $stable(pub_bits_r);
  endproperty
  a_cont_hold: assert property (p_cont_hold) else $error("continuous published early"); // RULE6

  property p_live;
    @(posedge clk_in) disable iff (!rst_b_in)
    ((state_r == bcr_pkg::ST_MEAS) && (mode_r != bcr_pkg::MODE_CONT))
    |=> (pub_bits_r == $past(bits_r)) && (pub_errs_r == $past(errs_r));
  endproperty
  a_live: assert property (p_live) else $error("live publish missing"); // RULE7

  property p_no_detect;
    @(posedge clk_in) disable iff (!rst_b_in)
    (!relock_r && (state_r == bcr_pkg::ST_MEAS) && !done_hit && !start_req && !stop_req)
    |=> (state_r == bcr_pkg::ST_MEAS);
  endproperty
  a_no_detect: assert property (p_no_detect) else $error("loss seen with relock off"); // RULE9

  property p_loss;
    @(posedge clk_in) disable iff (!rst_b_in)
    (loss_hit && !done_hit && !run_clr && !start_req && !stop_req)
    |=> (state_r == bcr_pkg::ST_SYNC) && (loss_r == $past(loss_r) + 16'h0001);
  endproperty
  a_loss: assert property (p_loss) else $error("loss not handled"); // RULE10 RULE18

  property p_sync_nocount;
    @(posedge clk_in) disable iff (!rst_b_in)
    ((state_r == bcr_pkg::ST_SYNC) && !start_req && !clr_req) |=> $stable(bits_r);
  endproperty
  a_sync_nocount: assert property (p_sync_nocount) else $error("counted before lock"); // RULE15
endmodule
`default_nettype wire

// file: bcr_link_src.sv
// Purpose: device-under-test model sending pn9 data with its bit clock
// Assumes: bits go out only on request; the bit clock idles low between frames
// Notes:   flip inverts sent data to inject bit errors; slow stalls each bit
`timescale 1ns/100ps
`default_nettype none
module bcr_link_src (
  // link towards the checker
  output var logic link_clk_out,
  output var logic link_data_out
);
  logic [8:0] lfsr_r = 9'h1ff;
  logic       nb;

  initial
  begin
    link_clk_out  = 1'b0;
    link_data_out = 1'b0;
  end

  // data moves 200 ns before the rising edge, so it is stable when sampled
  task automatic send(input int n, input logic flip, input logic slow);
    for (int i = 0; i < n; i++)
    begin
      nb            = lfsr_r[8] ^ lfsr_r[4];
      lfsr_r        = {lfsr_r[7:0], nb};
      link_data_out = nb ^ flip;
      #200;
      link_clk_out = 1'b1;
      #200;
      link_clk_out = 1'b0;
      if (slow)
      begin
        #400;
      end
    end
    // a released line must not look like the last bit
    #100;
    link_data_out = ~link_data_out;
  endtask
endmodule
`default_nettype wire

// file: bcr_ber_count_tb.sv
// Purpose: self-checking bench for the ber tally and resync block
// Assumes: partner sends pn9 bits on a 400 ns link clock
// Notes:   lock latency is not fixed, so counts are checked as deltas
`timescale 1ns/100ps
`default_nettype none
module bcr_ber_count_tb;
  logic        clk_in      = 1'b0;
  logic        rst_b_in    = 1'b0;
  logic [7:0]  addr_in     = 8'h00;
  logic [31:0] wr_data_in  = 32'h0;
  logic        wr_in       = 1'b0;
  logic        rd_in       = 1'b0;
  logic [31:0] rd_data_out;
  wire logic   lclk;
  wire logic   ldat;
  logic        locked_out;
  logic        running_out;
  int          n_mismatch  = 0;
  int          checks      = 0;
  logic [31:0] p;
  logic [31:0] b;

  always #25 clk_in = ~clk_in;

  bcr_ber_count dut_u (
    .clk_in       (clk_in),
    .rst_b_in     (rst_b_in),
    .addr_in      (addr_in),
    .wr_data_in   (wr_data_in),
    .wr_in        (wr_in),
    .rd_in        (rd_in),
    .rd_data_out  (rd_data_out),
    .link_clk_in  (lclk),
    .link_data_in (ldat),
    .locked_out   (locked_out),
    .running_out  (running_out)
  );

  bcr_link_src src_u (
    .link_clk_out  (lclk),
    .link_data_out (ldat)
  );

  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    wr_in      <= 1'b1;
    addr_in    <= a;
    wr_data_in <= d;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_in);
    rd_in   <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    @(negedge clk_in);
    d = rd_data_out;
  endtask

  task automatic wctl(input logic [1:0] md, input logic rl, input logic kp,
                      input logic [2:0] pl);
    wr(bcr_pkg::REG_CTRL, {22'h0, kp, rl, 2'h0, md, 1'b0, pl});
  endtask

  task automatic chk32(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk1(input string nm, input logic e, input logic g);
    checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("mismatch %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic chkr(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] g;
    rd(a, g);
    chk32(nm, e, g);
  endtask

  // wait covers sync, edge detect, count and publish stages
  task automatic send(input int n, input logic flip, input logic slow);
    src_u.send(n, flip, slow);
    repeat (8) @(posedge clk_in);
    @(negedge clk_in);
  endtask

  initial
  begin
    repeat (60000) @(posedge clk_in);
    n_mismatch++;
    conclude();
  end

  initial
  begin
    repeat (6) @(posedge clk_in);
    rst_b_in <= 1'b1;
    chkr("status", bcr_pkg::REG_STATUS, 32'h0);
    chkr("unmapped", 8'h2c, 32'h0);
    // single run with relock off
    wctl(bcr_pkg::MODE_SINGLE, 1'b0, 1'b0, 3'h0);
    wctl(bcr_pkg::MODE_SINGLE, 1'b0, 1'b0, 3'h1);
    chkr("sync state", bcr_pkg::REG_STATUS, 32'h1);
    send(40, 1'b0, 1'b0);
    chk1("locked", 1'b1, locked_out);
    rd(bcr_pkg::REG_PUB_BITS, b);
    send(100, 1'b0, 1'b1);
    chkr("bits live", bcr_pkg::REG_PUB_BITS, b + 32'h00000064);
    send(300, 1'b1, 1'b0);
    chk1("no loss", 1'b1, locked_out);
    chkr("errs live", bcr_pkg::REG_PUB_ERRS, 32'h0000012c);
    chkr("loss none", bcr_pkg::REG_PUB_LOSS, 32'h0);
    rd(bcr_pkg::REG_PROGRESS, p);
    wctl(bcr_pkg::MODE_SINGLE, 1'b0, 1'b0, 3'h4);
    chkr("bits clr", bcr_pkg::REG_PUB_BITS, 32'h0);
    chkr("errs clr", bcr_pkg::REG_PUB_ERRS, 32'h0);
    chkr("prog kept", bcr_pkg::REG_PROGRESS, p);
    chkr("log cnt", bcr_pkg::REG_LOG_CNT, 32'h1);
    chkr("log bits", bcr_pkg::REG_LOG_BITS, b + 32'h00000190);
    chkr("log errs", bcr_pkg::REG_LOG_ERRS, 32'h0000012c);
    chk1("lock kept", 1'b1, locked_out);
    send(1005 - int'(p), 1'b0, 1'b0);
    chkr("done", bcr_pkg::REG_STATUS, 32'h4);
    chkr("final bits", bcr_pkg::REG_PUB_BITS, 32'h000003e8 - p);
    send(20, 1'b0, 1'b0);
    chkr("frozen", bcr_pkg::REG_PUB_BITS, 32'h000003e8 - p);
    wctl(bcr_pkg::MODE_SINGLE, 1'b0, 1'b0, 3'h4);
    chkr("stop prog", bcr_pkg::REG_PROGRESS, 32'h0);
    chkr("stop bits", bcr_pkg::REG_PUB_BITS, 32'h0);
    chkr("stop errs", bcr_pkg::REG_PUB_ERRS, 32'h0);
    chkr("stop log", bcr_pkg::REG_LOG_CNT, 32'h1);
    // relock on, clear action, 50 in 500
    wr(bcr_pkg::REG_THRESH, 32'h00000032);
    wctl(bcr_pkg::MODE_SINGLE, 1'b1, 1'b0, 3'h0);
    wctl(bcr_pkg::MODE_SINGLE, 1'b1, 1'b0, 3'h1);
    send(60, 1'b0, 1'b0);
    send(49, 1'b1, 1'b0);
    chk1("below x", 1'b1, locked_out);
    send(1, 1'b1, 1'b0);
    chk1("loss unlock", 1'b0, locked_out);
    chkr("loss cnt", bcr_pkg::REG_PUB_LOSS, 32'h1);
    chkr("bits cleared", bcr_pkg::REG_PUB_BITS, 32'h0);
    send(40, 1'b0, 1'b0);
    chk1("relocked", 1'b1, locked_out);
    // keep action, x of zero acts as one
    wctl(bcr_pkg::MODE_SINGLE, 1'b1, 1'b1, 3'h2);
    wr(bcr_pkg::REG_THRESH, 32'h0);
    chkr("thresh raw", bcr_pkg::REG_THRESH, 32'h0);
    wctl(bcr_pkg::MODE_SINGLE, 1'b1, 1'b1, 3'h1);
    send(40, 1'b0, 1'b0);
    chkr("loss zero", bcr_pkg::REG_PUB_LOSS, 32'h0);
    send(1, 1'b1, 1'b0);
    chk1("x floor", 1'b0, locked_out);
    rd(bcr_pkg::REG_PUB_BITS, b);
    chk1("bits kept", 1'b1, b != 32'h0);
    // second reset in mid-run, then continuous mode
    @(posedge clk_in);
    rst_b_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rst_b_in <= 1'b1;
    chkr("ctrl rst", bcr_pkg::REG_CTRL, 32'h00000110);
    chkr("thresh rst", bcr_pkg::REG_THRESH, 32'h000000c8);
    chkr("target rst", bcr_pkg::REG_TARGET, 32'h000003e8);
    wctl(bcr_pkg::MODE_CONT, 1'b0, 1'b0, 3'h0);
    wctl(bcr_pkg::MODE_CONT, 1'b0, 1'b0, 3'h1);
    send(40, 1'b0, 1'b0);
    rd(bcr_pkg::REG_PROGRESS, p);
    chkr("cont pub", bcr_pkg::REG_PUB_BITS, 32'h0);
    wctl(bcr_pkg::MODE_CONT, 1'b0, 1'b0, 3'h4);
    chkr("cont prog", bcr_pkg::REG_PROGRESS, p);
    chkr("cont log", bcr_pkg::REG_LOG_CNT, 32'h0);
    send(1000 - int'(p), 1'b0, 1'b0);
    chkr("cont result", bcr_pkg::REG_PUB_BITS, 32'h000003e8);
    chk1("restart", 1'b1, running_out);
    chk1("resync", 1'b0, locked_out);
    // error count mode ends on the error target; endless ignores the target
    wr(bcr_pkg::REG_TARGET, 32'h00000005);
    wr(bcr_pkg::REG_CTRL, 32'h00000411);
    send(40, 1'b0, 1'b0);
    send(10, 1'b1, 1'b0);
    chkr("err done", bcr_pkg::REG_STATUS, 32'h00000004);
    chkr("err final", bcr_pkg::REG_PUB_ERRS, 32'h00000005);
    wr(bcr_pkg::REG_CTRL, 32'h00000021);
    send(40, 1'b0, 1'b0);
    chkr("endless on", bcr_pkg::REG_STATUS, 32'h00000002);
    conclude();
  end
endmodule
`default_nettype wire
